// ---- design/tco_regs.vh ----
// Descriptor field layout and fixed constants of the transmit context offload block
`ifndef TCO_REGS_VH
`define TCO_REGS_VH
// Context descriptor fields (bit positions in the 128-bit descriptor)
`define TCO_IPSS_LSB 0
`define TCO_IPSO_LSB 8
`define TCO_IPSE_LSB 16
`define TCO_L4SS_LSB 32
`define TCO_L4SO_LSB 40
`define TCO_L4SE_LSB 48
`define TCO_PLEN_LSB 64
`define TCO_DESCRIPTOR_TYPE_FIELD_LSB 84
`define TCO_CMD_LSB 88
`define TCO_HLEN_LSB 104
`define TCO_MSS_LSB 112
// Data descriptor fields
`define TCO_ADDR_LSB 0
`define TCO_DLEN_LSB 64
`define TCO_POPT_LSB 104
// Command byte bits
`define TCO_CMD_IDE 7
`define TCO_CMD_SNAP 6
`define TCO_CMD_DESCRIPTOR_EXTENSION_FLAG 5
`define TCO_CMD_RS 3
`define TCO_CMD_TSE 2
`define TCO_CMD_IPV4 1
`define TCO_CMD_TCP 0
`define TCO_CMD_EOP 0
// Option bits of a data descriptor
`define TCO_POPT_IP_SUM_INSERT_FLAG 0
`define TCO_POPT_L4_SUM_INSERT_FLAG 1
// Descriptor type codes
`define TCO_DESCRIPTOR_TYPE_FIELD_CTX 4'h0
`define TCO_DESCRIPTOR_TYPE_FIELD_DATA 4'h1
// Header layout offsets used when rewriting a prototype header
`define TCO_V4_LEN_OFF 8'h02
`define TCO_V6_LEN_OFF 8'h04
`define TCO_V6_HDR_LEN 16'h0028
`define TCO_SEQ_OFF 8'h04
`define TCO_SNAP_LEN_OFF 8'h0C
`define TCO_MAC_HDR_LEN 16'h000E
`define TCO_CSUM_BYTES 20'h00002
`endif

// ---- design/tco_ctx_offload.v ----
// Context descriptor parser, checksum context, segmentation engine and interrupt delay
`timescale 1ns/1ps
`default_nettype none
`include "tco_regs.vh"

// ************************************************************
// Descriptor FIFO
// ************************************************************
module tco_fifo #(
    parameter W  = 128,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output reg          in_ready,
    output wire [W-1:0] out_data,
    output reg          out_valid,
    input  wire         out_ready
);
    // Depth must equal 2**AW so the pointers wrap on their own
    localparam [AW:0] FULL = D;
    reg  [W-1:0]  mem [0:D-1];
    reg  [AW-1:0] wp_r;
    reg  [AW-1:0] rp_r;
    reg  [AW:0]   cnt_r;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;
    wire [AW:0]   cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always @(posedge clk) begin
        if (push)
            mem[wp_r] <= in_data;
        if (rst) begin
            wp_r      <= {AW{1'b0}};
            rp_r      <= {AW{1'b0}};
            cnt_r     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            cnt_r     <= cnt_nxt;
            in_ready  <= (cnt_nxt != FULL);
            out_valid <= (cnt_nxt != {(AW+1){1'b0}});
        end
    end

    assign out_data = mem[rp_r];
endmodule // tco_fifo

// ************************************************************
// Top level
// ************************************************************
module tco_ctx_offload #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [127:0] desc_data,
    input  wire         desc_valid,
    output wire         desc_ready,
    input  wire [15:0]  delay_interval_value,
    input  wire         writeback_interrupt_cause,
    input  wire         wb_ready,
    output reg          wb_valid_r,
    output reg          wb_done_r,
    output reg          tx_irq_r,
    output reg          chk_valid_r,
    output reg          chk_seg_r,
    output reg  [7:0]   ip_start_r,
    output reg  [7:0]   ip_off_r,
    output reg  [15:0]  ip_end_r,
    output reg  [7:0]   l4_start_r,
    output reg  [7:0]   l4_off_r,
    output reg  [15:0]  l4_end_r,
    output reg          ip_ins_r,
    output reg          l4_ins_r,
    input  wire [7:0]   bin_data,
    input  wire         bin_valid,
    output reg          bin_ready_r,
    output reg  [7:0]   bout_data_r,
    output reg          bout_valid_r,
    output reg          bout_last_r,
    input  wire         bout_ready
);
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_HDR  = 5'b00010;
    localparam [4:0] S_FRM  = 5'b00100;
    localparam [4:0] S_EH   = 5'b01000;
    localparam [4:0] S_EP   = 5'b10000;

    // Two checksum bytes must fit inside the packet
    function fits;
        input [7:0]  off;
        input [19:0] len;
        begin
            fits = ({12'h000, off} + `TCO_CSUM_BYTES) <= len;
        end
    endfunction

    wire [127:0] d;
    wire         f_valid;
    // A pending write-back holds the FIFO, which backs up to the fetch side
    wire         f_ready = ~wb_valid_r | wb_ready;
    wire         pop = f_valid & f_ready;

    tco_fifo #(
        .W  (128),
        .D  (FIFO_DEPTH),
        .AW (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (desc_data),
        .in_valid  (desc_valid),
        .in_ready  (desc_ready),
        .out_data  (d),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    wire [7:0]  cmd    = d[`TCO_CMD_LSB +: 8];
    wire [3:0]  descriptor_type_field   = d[`TCO_DESCRIPTOR_TYPE_FIELD_LSB +: 4];
    wire        segmentation_enable_flag    = cmd[`TCO_CMD_TSE];
    wire        is_ctx = cmd[`TCO_CMD_DESCRIPTOR_EXTENSION_FLAG] & (descriptor_type_field == `TCO_DESCRIPTOR_TYPE_FIELD_CTX);
    wire        is_dat = cmd[`TCO_CMD_DESCRIPTOR_EXTENSION_FLAG] & (descriptor_type_field == `TCO_DESCRIPTOR_TYPE_FIELD_DATA);
    wire [19:0] dlen   = d[`TCO_DLEN_LSB +: 20];
    // Null address or zero length moves no data
    wire        nonnull = (d[`TCO_ADDR_LSB +: 64] != 64'h0) & (dlen != 20'h0);

    // ************************************************************
    // Context store: index 0 checksum, 1 segmentation
    // ************************************************************
    reg  [7:0]  ip_ss [0:1];
    reg  [7:0]  ip_so [0:1];
    reg  [15:0] ip_se [0:1];
    reg  [7:0]  l4_ss [0:1];
    reg  [7:0]  l4_so [0:1];
    reg  [15:0] l4_se [0:1];
    reg  [15:0] s_mss_r;
    reg  [7:0]  s_hlen_r;
    reg  [19:0] s_plen_r;
    reg         s_snap_r;
    reg         s_v4_r;
    reg         s_tcp_r;
    reg         seg_go_r;
    reg  [19:0] pk_len_r;
    reg         pk_first_r;
    reg         pk_tse_r;
    reg  [1:0]  pk_popt_r;
    reg         wb_ide_r;
    reg  [15:0] dly_r;
    integer     i;

    wire        ktse  = pk_first_r ? segmentation_enable_flag : pk_tse_r;
    wire [1:0]  popt  = pk_first_r ? d[`TCO_POPT_LSB +: 2] : pk_popt_r;
    wire [19:0] len_t = pk_len_r + (nonnull ? dlen : 20'h0);

    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 2; i = i + 1) begin
                ip_ss[i] <= 8'h00;
                ip_so[i] <= 8'h00;
                ip_se[i] <= 16'h0000;
                l4_ss[i] <= 8'h00;
                l4_so[i] <= 8'h00;
                l4_se[i] <= 16'h0000;
            end
            s_mss_r     <= 16'h0000;
            s_hlen_r    <= 8'h00;
            s_plen_r    <= 20'h00000;
            s_snap_r    <= 1'b0;
            s_v4_r      <= 1'b0;
            s_tcp_r     <= 1'b0;
            seg_go_r    <= 1'b0;
            pk_len_r    <= 20'h00000;
            pk_first_r  <= 1'b1;
            pk_tse_r    <= 1'b0;
            pk_popt_r   <= 2'b00;
            chk_valid_r <= 1'b0;
            chk_seg_r   <= 1'b0;
            ip_start_r  <= 8'h00;
            ip_off_r    <= 8'h00;
            ip_end_r    <= 16'h0000;
            l4_start_r  <= 8'h00;
            l4_off_r    <= 8'h00;
            l4_end_r    <= 16'h0000;
            ip_ins_r    <= 1'b0;
            l4_ins_r    <= 1'b0;
            wb_valid_r  <= 1'b0;
            wb_done_r   <= 1'b0;
            wb_ide_r    <= 1'b0;
        end else begin
            seg_go_r    <= 1'b0;
            chk_valid_r <= 1'b0;
            if (wb_valid_r & wb_ready)
                wb_valid_r <= 1'b0;
            if (pop & is_ctx) begin
                // The chosen context is overwritten at once, even mid-packet
                ip_ss[segmentation_enable_flag] <= d[`TCO_IPSS_LSB +: 8];
                ip_so[segmentation_enable_flag] <= d[`TCO_IPSO_LSB +: 8];
                ip_se[segmentation_enable_flag] <= d[`TCO_IPSE_LSB +: 16];
                l4_ss[segmentation_enable_flag] <= d[`TCO_L4SS_LSB +: 8];
                l4_so[segmentation_enable_flag] <= d[`TCO_L4SO_LSB +: 8];
                l4_se[segmentation_enable_flag] <= d[`TCO_L4SE_LSB +: 16];
                if (segmentation_enable_flag) begin
                    // Segmentation-only bits are dropped without the enable
                    s_mss_r  <= d[`TCO_MSS_LSB +: 16];
                    s_hlen_r <= d[`TCO_HLEN_LSB +: 8];
                    s_plen_r <= d[`TCO_PLEN_LSB +: 20];
                    s_snap_r <= cmd[`TCO_CMD_SNAP];
                    s_v4_r   <= cmd[`TCO_CMD_IPV4];
                    s_tcp_r  <= cmd[`TCO_CMD_TCP];
                    seg_go_r <= 1'b1;
                end
            end
            if (pop & is_dat) begin
                if (pk_first_r) begin
                    pk_tse_r  <= segmentation_enable_flag;
                    pk_popt_r <= d[`TCO_POPT_LSB +: 2];
                end
                pk_first_r <= cmd[`TCO_CMD_EOP];
                pk_len_r   <= cmd[`TCO_CMD_EOP] ? 20'h00000 : len_t;
                if (cmd[`TCO_CMD_EOP]) begin
                    chk_valid_r <= 1'b1;
                    chk_seg_r   <= ktse;
                    ip_start_r  <= ip_ss[ktse];
                    ip_off_r    <= ip_so[ktse];
                    ip_end_r    <= (ip_se[ktse] == 16'h0000) ? len_t[15:0] - 16'h0001
                                                             : ip_se[ktse];
                    l4_start_r  <= l4_ss[ktse];
                    l4_off_r    <= l4_so[ktse];
                    l4_end_r    <= (l4_se[ktse] == 16'h0000) ? len_t[15:0] - 16'h0001
                                                             : l4_se[ktse];
                    ip_ins_r    <= popt[`TCO_POPT_IP_SUM_INSERT_FLAG] & fits(ip_so[ktse], len_t);
                    l4_ins_r    <= popt[`TCO_POPT_L4_SUM_INSERT_FLAG] & fits(l4_so[ktse], len_t);
                end
            end
            // Done is reported at fetch, not held back for the delay timer
            if (pop & cmd[`TCO_CMD_RS]) begin
                wb_valid_r <= 1'b1;
                wb_done_r  <= 1'b1;
                wb_ide_r   <= cmd[`TCO_CMD_IDE];
            end
        end
    end

    // ************************************************************
    // Transmit interrupt delay
    // ************************************************************
    wire wb_fire = wb_valid_r & wb_ready;

    always @(posedge clk) begin
        if (rst) begin
            dly_r    <= 16'h0000;
            tx_irq_r <= 1'b0;
        end else if (wb_fire & wb_ide_r & (delay_interval_value != 16'h0000)) begin
            dly_r    <= delay_interval_value;
            tx_irq_r <= 1'b0;
        end else if (wb_fire) begin
            dly_r    <= 16'h0000;
            tx_irq_r <= writeback_interrupt_cause;
        end else if (dly_r != 16'h0000) begin
            dly_r    <= dly_r - 16'h0001;
            tx_irq_r <= (dly_r == 16'h0001) & writeback_interrupt_cause;
        end else begin
            tx_irq_r <= 1'b0;
        end
    end

    // ************************************************************
    // Segmentation engine
    // ************************************************************
    reg  [7:0]  hmem [0:255];
    reg  [4:0]  st_r;
    reg  [7:0]  hcnt_r;
    reg  [15:0] seg_len_r;
    reg  [15:0] scnt_r;
    reg  [19:0] left_r;
    reg  [19:0] sent_r;
    reg  [7:0]  hb;
    reg  [15:0] ipl;
    reg  [31:0] seq;

    wire        bin_go   = bin_valid & bin_ready_r;
    wire        out_free = ~bout_valid_r | bout_ready;
    wire [15:0] frm_len  = {8'h00, s_hlen_r} + seg_len_r;
    wire [7:0]  ipl_at   = ip_ss[1] + (s_v4_r ? `TCO_V4_LEN_OFF : `TCO_V6_LEN_OFF);
    wire [7:0]  seq_at   = l4_ss[1] + `TCO_SEQ_OFF;
    wire [15:0] snap_len = frm_len - `TCO_MAC_HDR_LEN;

    // Prototype byte with the per-frame fields patched in on the way out
    always @* begin
        hb  = hmem[hcnt_r];
        seq = {hmem[seq_at], hmem[seq_at + 8'h01], hmem[seq_at + 8'h02],
               hmem[seq_at + 8'h03]} + {12'h000, sent_r};
        ipl = frm_len - {8'h00, ip_ss[1]};
        if (!s_v4_r)
            ipl = ipl - `TCO_V6_HDR_LEN;
        if (hcnt_r == ipl_at)
            hb = ipl[15:8];
        if (hcnt_r == ipl_at + 8'h01)
            hb = ipl[7:0];
        if (s_tcp_r) begin
            if (hcnt_r == seq_at)
                hb = seq[31:24];
            if (hcnt_r == seq_at + 8'h01)
                hb = seq[23:16];
            if (hcnt_r == seq_at + 8'h02)
                hb = seq[15:8];
            if (hcnt_r == seq_at + 8'h03)
                hb = seq[7:0];
        end
        if (s_snap_r & (hcnt_r == `TCO_SNAP_LEN_OFF))
            hb = snap_len[15:8];
        if (s_snap_r & (hcnt_r == `TCO_SNAP_LEN_OFF + 8'h01))
            hb = snap_len[7:0];
    end

    always @(posedge clk) begin
        if (bin_go & (st_r == S_HDR))
            hmem[hcnt_r] <= bin_data;
        if (rst) begin
            st_r         <= S_IDLE;
            hcnt_r       <= 8'h00;
            seg_len_r    <= 16'h0000;
            scnt_r       <= 16'h0000;
            left_r       <= 20'h00000;
            sent_r       <= 20'h00000;
            bin_ready_r  <= 1'b0;
            bout_valid_r <= 1'b0;
            bout_data_r  <= 8'h00;
            bout_last_r  <= 1'b0;
        end else begin
            // Last marks only the byte it travels with
            if (bout_valid_r & bout_ready) begin
                bout_valid_r <= 1'b0;
                bout_last_r  <= 1'b0;
            end
            case (st_r)
                S_IDLE: begin
                    bin_ready_r <= 1'b0;
                end
                S_HDR: begin
                    if (bin_go) begin
                        hcnt_r <= hcnt_r + 8'h01;
                        if (hcnt_r == s_hlen_r - 8'h01) begin
                            bin_ready_r <= 1'b0;
                            st_r        <= S_FRM;
                        end
                    end
                end
                S_FRM: begin
                    seg_len_r <= (left_r > {4'h0, s_mss_r}) ? s_mss_r : left_r[15:0];
                    hcnt_r    <= 8'h00;
                    scnt_r    <= 16'h0000;
                    st_r      <= (left_r == 20'h00000) ? S_IDLE : S_EH;
                end
                S_EH: begin
                    if (out_free) begin
                        bout_valid_r <= 1'b1;
                        bout_data_r  <= hb;
                        bout_last_r  <= 1'b0;
                        hcnt_r       <= hcnt_r + 8'h01;
                        if (hcnt_r == s_hlen_r - 8'h01)
                            st_r <= S_EP;
                    end
                end
                S_EP: begin
                    // One byte in flight at a time keeps ready a plain flop
                    if (bin_go) begin
                        bout_valid_r <= 1'b1;
                        bout_data_r  <= bin_data;
                        bout_last_r  <= (scnt_r == seg_len_r - 16'h0001);
                        bin_ready_r  <= 1'b0;
                        scnt_r       <= scnt_r + 16'h0001;
                        left_r       <= left_r - 20'h00001;
                        sent_r       <= sent_r + 20'h00001;
                    end else if (!bin_ready_r & out_free) begin
                        if (scnt_r == seg_len_r)
                            st_r <= S_FRM;
                        else
                            bin_ready_r <= 1'b1;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
            // A new segmentation context restarts the engine immediately
            if (seg_go_r) begin
                st_r        <= (s_hlen_r == 8'h00) ? S_FRM : S_HDR;
                hcnt_r      <= 8'h00;
                left_r      <= s_plen_r;
                sent_r      <= 20'h00000;
                bin_ready_r <= (s_hlen_r != 8'h00);
            end
        end
    end
endmodule // tco_ctx_offload
`default_nettype wire

// ---- verification/tco_ctx_offload_asserts.sv ----
// Concurrent checks on the ports of the transmit context offload block
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module tco_ctx_offload_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       desc_ready,
    input wire logic       writeback_interrupt_cause,
    input wire logic       wb_ready,
    input wire logic       wb_valid_r,
    input wire logic       wb_done_r,
    input wire logic       tx_irq_r,
    input wire logic       chk_valid_r,
    input wire logic [7:0] bout_data_r,
    input wire logic       bout_valid_r,
    input wire logic       bout_last_r,
    input wire logic       bout_ready
);
    logic wb_seen_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // An interrupt may only follow some accepted write-back
    always_ff @(posedge clk) begin
        if (rst)
            wb_seen_r <= 1'b0;
        else if (wb_valid_r && wb_ready)
            wb_seen_r <= 1'b1;
    end
    wb_hold_a: assert property (wb_valid_r && !wb_ready |=> wb_valid_r)
        else $error("write-back withdrawn before taken");
    done_set_a: assert property (wb_valid_r |-> wb_done_r)
        else $error("write-back without done flag");
    done_keep_a: assert property (wb_done_r |=> wb_done_r)
        else $error("done flag lost");
    irq_cause_a: assert property (tx_irq_r |-> $past(writeback_interrupt_cause))
        else $error("interrupt while cause disabled");
    irq_after_wb_a: assert property (tx_irq_r |-> wb_seen_r)
        else $error("interrupt without write-back");
    last_valid_a: assert property (bout_last_r |-> bout_valid_r)
        else $error("frame end without byte");
    bout_hold_a: assert property (bout_valid_r && !bout_ready |=>
        bout_valid_r && $stable(bout_data_r) && $stable(bout_last_r))
        else $error("output byte changed while stalled");
    reset_quiet_a: assert property ($past(rst) |-> desc_ready && !wb_valid_r
        && !tx_irq_r && !chk_valid_r && !bout_valid_r)
        else $error("outputs active after reset");
endmodule // tco_ctx_offload_chk

bind tco_ctx_offload tco_ctx_offload_chk u_chk (
    .clk(clk), .rst(rst), .desc_ready(desc_ready),
    .writeback_interrupt_cause(writeback_interrupt_cause), .wb_ready(wb_ready),
    .wb_valid_r(wb_valid_r), .wb_done_r(wb_done_r), .tx_irq_r(tx_irq_r),
    .chk_valid_r(chk_valid_r), .bout_data_r(bout_data_r), .bout_valid_r(bout_valid_r),
    .bout_last_r(bout_last_r), .bout_ready(bout_ready)
);
`default_nettype wire

// ---- verification/tco_host_model.sv ----
// Host-side model: takes status write-backs and sinks frames, with stalls
`timescale 1ns/1ps
`default_nettype none
// ********
// Host model
// ********
module tco_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       stall,
    input  wire logic       wb_valid_r,
    output logic            wb_ready,
    output logic            bout_ready,
    output logic [7:0]      wb_count
);
    logic tog_r;
    // Under stall the sink is ready only every other cycle, so holds get exercised
    assign wb_ready = !stall;
    assign bout_ready = !stall || tog_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            tog_r <= 1'b0;
            wb_count <= 8'h00;
        end else begin
            tog_r <= !tog_r;
            if (wb_valid_r && wb_ready)
                wb_count <= wb_count + 8'h01;
        end
    end
endmodule // tco_host_model
`default_nettype wire

// ---- verification/tco_ctx_offload_tb.sv ----
// Self-checking testbench of the transmit context offload block
`timescale 1ns/1ps
`default_nettype none
`include "tco_regs.vh"
// ********
// Testbench
// ********
module tco_ctx_offload_tb;
    logic clk = 0, rst = 1, desc_valid = 0, cause = 1, bin_valid = 0, stall = 0;
    logic [127:0] desc_data = '0;
    logic [15:0] dly = 16'h0014;
    logic [7:0] bin_data = 8'h00;
    wire desc_ready, wb_ready, wb_valid_r, wb_done_r, tx_irq_r, chk_valid_r, chk_seg_r;
    wire ip_ins_r, l4_ins_r, bin_ready_r, bout_valid_r, bout_last_r, bout_ready;
    wire [7:0] ip_start_r, ip_off_r, l4_start_r, l4_off_r, bout_data_r, wb_count;
    wire [15:0] ip_end_r, l4_end_r;
    logic [7:0] ob [0:511];
    logic [66:0] cs;
    logic [7:0] ct [0:3] = '{8'hA8, 8'h28, 8'hA0, 8'h28};
    int ed [0:3] = '{21, 1, 0, 0};
    int fs [0:4];
    int cyc = 0, last_take = 0, last_irq = 0, irq_n = 0, chk_n = 0, oc = 0, frm = 0;
    int acc = 0, miscompares = 0, samples_checked = 0, k, n0, w0, a0;
    localparam logic [66:0] EXP_B = {1'b0, 8'h0E, 8'h3A, 16'h0020, 8'h22, 8'h3B, 16'h0040, 2'b10};

    tco_ctx_offload uut (.clk(clk), .rst(rst), .desc_data(desc_data), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .delay_interval_value(dly), .writeback_interrupt_cause(cause),
        .wb_ready(wb_ready), .wb_valid_r(wb_valid_r), .wb_done_r(wb_done_r),
        .tx_irq_r(tx_irq_r), .chk_valid_r(chk_valid_r), .chk_seg_r(chk_seg_r),
        .ip_start_r(ip_start_r), .ip_off_r(ip_off_r), .ip_end_r(ip_end_r),
        .l4_start_r(l4_start_r), .l4_off_r(l4_off_r), .l4_end_r(l4_end_r),
        .ip_ins_r(ip_ins_r), .l4_ins_r(l4_ins_r), .bin_data(bin_data), .bin_valid(bin_valid),
        .bin_ready_r(bin_ready_r), .bout_data_r(bout_data_r), .bout_valid_r(bout_valid_r),
        .bout_last_r(bout_last_r), .bout_ready(bout_ready));
    tco_host_model u_host (.clk(clk), .rst(rst), .stall(stall), .wb_valid_r(wb_valid_r),
        .wb_ready(wb_ready), .bout_ready(bout_ready), .wb_count(wb_count));

    initial forever #2.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wb_valid_r && wb_ready) last_take <= cyc;
        if (tx_irq_r) begin
            irq_n <= irq_n + 1;
            last_irq <= cyc;
        end
        if (chk_valid_r) begin
            chk_n <= chk_n + 1;
            cs <= {chk_seg_r, ip_start_r, ip_off_r, ip_end_r, l4_start_r, l4_off_r, l4_end_r,
                   ip_ins_r, l4_ins_r};
        end
        if (bout_valid_r && bout_ready) begin
            ob[oc] <= bout_data_r;
            oc <= oc + 1;
            if (bout_last_r) begin
                frm <= frm + 1;
                fs[frm + 1] <= oc + 1;
            end
        end
        if (desc_valid && desc_ready) acc <= acc + 1;
        // Whole run needs well under two thousand cycles
        if (cyc == 20000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    function automatic logic [127:0] ctx(input logic [7:0] ss, so, input logic [15:0] se,
        input logic [7:0] ts, to, input logic [15:0] te, input logic [19:0] pl,
        input logic [7:0] cmd, hl, input logic [15:0] ms);
        ctx = '0;
        ctx[`TCO_IPSS_LSB +: 8] = ss;
        ctx[`TCO_IPSO_LSB +: 8] = so;
        ctx[`TCO_IPSE_LSB +: 16] = se;
        ctx[`TCO_L4SS_LSB +: 8] = ts;
        ctx[`TCO_L4SO_LSB +: 8] = to;
        ctx[`TCO_L4SE_LSB +: 16] = te;
        ctx[`TCO_PLEN_LSB +: 20] = pl;
        ctx[`TCO_DESCRIPTOR_TYPE_FIELD_LSB +: 4] = `TCO_DESCRIPTOR_TYPE_FIELD_CTX;
        ctx[`TCO_CMD_LSB +: 8] = cmd;
        ctx[`TCO_HLEN_LSB +: 8] = hl;
        ctx[`TCO_MSS_LSB +: 16] = ms;
    endfunction

    function automatic logic [127:0] ictx(input logic [7:0] cmd);
        ictx = ctx(8'h00, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, 20'h00000, cmd, 8'h00,
                   16'h0000);
    endfunction

    function automatic logic [127:0] dat(input logic [63:0] a, input logic [19:0] len,
        input logic [7:0] cmd, po);
        dat = '0;
        dat[`TCO_ADDR_LSB +: 64] = a;
        dat[`TCO_DLEN_LSB +: 20] = len;
        dat[`TCO_DESCRIPTOR_TYPE_FIELD_LSB +: 4] = `TCO_DESCRIPTOR_TYPE_FIELD_DATA;
        dat[`TCO_CMD_LSB +: 8] = cmd;
        dat[`TCO_POPT_LSB +: 8] = po;
    endfunction

    function automatic logic [15:0] hw(input int f, input int off);
        hw = {ob[fs[f] + off], ob[fs[f] + off + 1]};
    endfunction

    task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [127:0] d);
        @(posedge clk);
        desc_data <= d;
        desc_valid <= 1'b1;
        @(posedge clk);
        while (desc_ready !== 1'b1) @(posedge clk);
        desc_valid <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic feed(input int n);
        for (int j = 0; j < n; j++) begin
            bin_data <= (j < 54) ? j[7:0] : 8'h80 + j[7:0] - 8'd54;
            bin_valid <= 1'b1;
            @(posedge clk);
            while (bin_ready_r !== 1'b1) @(posedge clk);
        end
        bin_valid <= 1'b0;
    endtask

    task automatic wait_chk(input int n);
        for (int j = 0; j < 200 && chk_n < n; j++) @(posedge clk);
    endtask

    task automatic irq_pair(input logic [7:0] c1, input logic [7:0] c2, input int ediff);
        n0 = irq_n;
        send(ictx(c1));
        idle(8);
        send(ictx(c2));
        idle(40);
        cmp(irq_n - n0, 1);
        cmp(last_irq - last_take, ediff);
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        cmp({desc_ready, wb_valid_r, tx_irq_r, chk_valid_r, bout_valid_r}, 5'b10000);
        send(ctx(8'h0E, 8'h18, 16'h0000, 8'h22, 8'h32, 16'h0000, 20'h0, 8'h20, 8'h00,
                 16'h0000));
        send(dat(64'h1000, 20'd100, 8'h21, 8'h03));
        wait_chk(1);
        cmp(cs, {1'b0, 8'h0E, 8'h18, 16'h0063, 8'h22, 8'h32, 16'h0063, 2'b11});
        // Extra command bits are set here and must change nothing without segmentation
        send(ctx(8'h0E, 8'h3A, 16'h0020, 8'h22, 8'h3B, 16'h0040, 20'h0, 8'h63, 8'h00,
                 16'h0000));
        send(dat(64'h0, 20'd50, 8'h28, 8'h03));
        send(dat(64'h2000, 20'd60, 8'h21, 8'h03));
        wait_chk(2);
        cmp(cs, EXP_B);
        cmp(wb_count, 1);
        cmp(wb_done_r, 1'b1);
        stall <= 1'b1;
        send(ctx(8'h0E, 8'h18, 16'h0000, 8'h22, 8'h32, 16'h0000, 20'd40, 8'h27, 8'd54,
                 16'h0011));
        feed(94);
        for (k = 0; k < 2000 && frm < 3; k++) @(posedge clk);
        stall <= 1'b0;
        cmp(frm, 3);
        cmp(oc, 202);
        cmp(fs[1] - fs[0], 71);
        cmp(oc - fs[2], 60);
        cmp({hw(0, 16), hw(1, 16), hw(2, 16)}, 48'h0039_0039_002E);
        cmp({hw(0, 38), hw(0, 40), hw(1, 38), hw(1, 40), hw(2, 38), hw(2, 40)},
            96'h26272829_2627283A_2627284B);
        cmp({ob[fs[2] + 53], ob[fs[1] + 54], ob[fs[2] + 54], ob[fs[2] + 59]}, 32'h3591A2A7);
        // IPv6 with SNAP: the length word moves and one short frame results
        send(ctx(8'h0E, 8'h18, 16'h0000, 8'h22, 8'h32, 16'h0000, 20'd4, 8'h65, 8'd54,
                 16'h0011));
        feed(58);
        for (k = 0; k < 400 && frm < 4; k++) @(posedge clk);
        cmp(frm, 4);
        cmp(oc - fs[3], 58);
        cmp({hw(3, 12), hw(3, 16), hw(3, 18)}, 48'h002C_1011_0004);
        send(dat(64'h3000, 20'd60, 8'h21, 8'h03));
        wait_chk(3);
        cmp(cs, EXP_B);
        for (k = 0; k < 4; k++) begin
            cause <= (k != 3);
            n0 = irq_n;
            w0 = wb_count;
            send(ictx(ct[k]));
            idle(40);
            cmp(irq_n - n0, ed[k] != 0);
            if (ed[k] != 0) cmp(last_irq - last_take, ed[k]);
            cmp(wb_count - w0, ct[k][3]);
        end
        cause <= 1'b1;
        irq_pair(8'hA8, 8'hA8, 21);
        irq_pair(8'hA8, 8'h28, 1);
        stall <= 1'b1;
        a0 = acc;
        w0 = wb_count;
        for (k = 0; k < 24; k++) begin
            @(posedge clk);
            if (desc_ready === 1'b1) send(ictx(8'h28));
        end
        cmp(desc_ready, 1'b0);
        stall <= 1'b0;
        for (k = 0; k < 400 && wb_count - w0 != acc - a0; k++) @(posedge clk);
        cmp(wb_count - w0, acc - a0);
        cmp(desc_ready, 1'b1);
        end_of_test();
    end
endmodule // tco_ctx_offload_tb
`default_nettype wire
